// File: common/panel_pkg.sv
package panel_pkg;
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned ROTATE_S = 2;
  localparam int unsigned HOLD_S = 2;
  localparam int unsigned UNLOCK_MIN = 10;
  localparam int unsigned COMMIT_MIN = 10;
  localparam int unsigned ROTATE_CYC = CLK_HZ * ROTATE_S;
  localparam int unsigned HOLD_CYC = CLK_HZ * HOLD_S;
  localparam longint unsigned UNLOCK_CYC = longint'(CLK_HZ) * 60 * UNLOCK_MIN;
  localparam longint unsigned COMMIT_CYC = longint'(CLK_HZ) * 60 * COMMIT_MIN;
  localparam longint unsigned HOUR_CYC = longint'(CLK_HZ) * 3600;
  localparam logic [13:0] RUNLIM_MIN = 14'h000A;
  localparam logic [13:0] RUNLIM_MAX = 14'h2238;
  localparam logic [7:0] PASSWORD = 8'h00;
  localparam int unsigned HIST_DEPTH = 5;
  localparam logic [7:0] LOAD_BAR_LO = 8'h32;
  localparam logic [7:0] LOAD_BAR_HI = 8'h78;
  localparam int unsigned BLINK_CYC = CLK_HZ / 4;
  localparam logic [3:0] CAUSE_NONE = 4'h0;
  localparam logic [3:0] CAUSE_TEST = 4'hF;
  localparam logic [3:0] CAUSE_OVERLOAD = 4'h1;
  typedef enum logic [3:0] {
    SCR_MEAS, SCR_TEST, SCR_GROUP, SCR_ITEM, SCR_VALUE, SCR_PASS, SCR_EDIT, SCR_HIST, SCR_DETAIL
  } screen_e;
endpackage : panel_pkg

// File: design/relay_panel_operation_logic.sv
`timescale 1ns/100ps
// What this block does
// - one test/reset press while untripped shows test and forces a trip
// - test/reset while tripped clears trip and returns to measurement
// - test/reset does not test or reset a trip while the motor runs
// - enter opens group select; up/down steps; enter opens; test/reset returns
// - in a group up/down picks item, enter shows value, test/reset goes back
// - up/down on value asks password P-00; then value flickers, enter stores
// - after store enter goes to next item, test/reset to previous item
// - unlock lasts until 10 minutes without a change
// - down+up shows latest trip cause, or none when empty
// - in history up/down steps events, enter shows detail
// - history keeps five entries, oldest dropped when full
// - runtime limit 10..8760 h; reaching it raises alarm and optional contact
// - shown operating time is zero with no motor current
// - total run time is committed every 10 minutes
// - thermal build-up mode plain reset keeps heat after overload trip
// - enter+test/reset during overcurrent trip clears heat to cold
// - measurement rotates through three phases every 2 seconds
// - enter held 2 s freezes phase only if already held when measurement is re-entered; a fresh press opens group select, which stops the hold count
// - load bar spans 50..120 percent and flickers at or above 120
// - comm indicator flickers during serial activity
// - display link loss latches a fault indication
// - backup memory fault latches a fault indication
module relay_panel_operation_logic
  import panel_pkg::*;
#(
  parameter int unsigned ROT_CYC = ROTATE_CYC,
  parameter int unsigned HOLD_CYCLES = HOLD_CYC,
  parameter longint unsigned UNLOCK_CYCLES = UNLOCK_CYC,
  parameter longint unsigned COMMIT_CYCLES = COMMIT_CYC,
  parameter longint unsigned HOUR_CYCLES = HOUR_CYC,
  parameter int unsigned BLINK_CYCLES = BLINK_CYC,
  parameter int unsigned GROUPS = 2,
  parameter int unsigned ITEMS = 23
) (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic CLK_EN,
  input wire logic BTN_TEST_RESET,
  input wire logic BTN_ENTER,
  input wire logic BTN_UP,
  input wire logic BTN_DOWN,
  input wire logic MOTOR_RUNNING,
  input wire logic CURRENT_FLOWING,
  input wire logic PROT_TRIP,
  input wire logic [3:0] PROT_CAUSE,
  input wire logic THERMAL_BUILDUP_CURVE,
  input wire logic [7:0] LOAD_FACTOR,
  input wire logic COMM_ACTIVE,
  input wire logic LINK_LOST,
  input wire logic BACKUP_FAULT,
  input wire logic [13:0] RUNTIME_LIMIT_HOURS,
  input wire logic ALARM_SRC_RUNTIME,
  input wire logic [13:0] NV_RUN_HOURS,
  output logic [3:0] SCREEN,
  output logic TRIPPED,
  output logic TEST_SHOWN,
  output logic THERMAL_CLEAR,
  output logic [4:0] GROUP_SEL,
  output logic [4:0] ITEM_SEL,
  output logic [7:0] PASS_VALUE,
  output logic VALUE_FLICKER,
  output logic VALUE_INC,
  output logic VALUE_DEC,
  output logic VALUE_STORE,
  output logic UNLOCKED,
  output logic [3:0] HIST_CAUSE,
  output logic [2:0] HIST_INDEX,
  output logic [2:0] HIST_COUNT,
  output logic [1:0] PHASE_SEL,
  output logic PHASE_FLICKER,
  output logic [7:0] LOAD_BAR,
  output logic LOAD_BAR_FLICKER,
  output logic COMM_LAMP,
  output logic LINK_FAULT,
  output logic MEM_FAULT,
  output logic RUNTIME_LIMIT_ALARM,
  output logic ALARM_CONTACT,
  output logic [13:0] OP_HOURS,
  output logic [13:0] TOTAL_HOURS,
  output logic NV_COMMIT
);
  typedef struct packed {
    logic [1:0][4:0] s_te;
    logic [1:0][4:0] s_en;
    logic [1:0][4:0] s_up;
    logic [1:0][4:0] s_dn;
    logic [1:0] s_run;
    logic [1:0] s_cur;
    logic [1:0] s_trip;
    logic [1:0] s_thb;
    logic [1:0] s_com;
    logic [1:0] s_lnk;
    logic [1:0] s_mem;
    logic [3:0] p_te;
    logic [3:0] p_en;
    logic [3:0] p_up;
    logic [3:0] p_dn;
    screen_e scr;
    logic tripped;
    logic overload;
    logic heat_clr;
    logic [4:0] grp;
    logic [4:0] item;
    logic [7:0] pass;
    logic unlocked;
    logic [35:0] unlock_cnt;
    logic inc;
    logic dec;
    logic store;
    logic [HIST_DEPTH-1:0][3:0] hist;
    logic [2:0] hcnt;
    logic [2:0] hidx;
    logic [1:0] phase;
    logic frozen;
    logic [31:0] rot_cnt;
    logic [31:0] hold_cnt;
    logic [31:0] blink_cnt;
    logic blink;
    logic [7:0] bar;
    logic bar_hi;
    logic comm_lamp;
    logic link_f;
    logic mem_f;
    logic [37:0] hour_cnt;
    logic [13:0] op_h;
    logic [13:0] tot_h;
    logic [35:0] commit_cnt;
    logic commit;
    logic rt_alarm;
    logic alarm_ct;
    logic loaded;
  } state_s;

  state_s state_reg, state_next;

  function automatic logic edge_of(input logic [4:0] sync);
    edge_of = sync[1] & ~sync[2];
  endfunction : edge_of

  logic te, en, up, dn, both_ud, both_et;
  logic [4:0] raw_sync;
  logic [13:0] lim;
  always_comb begin
    state_next = state_reg;
    // two flops first; extra taps only read the second flop, for edges and combos
    state_next.s_te = {state_reg.s_te[0], state_reg.s_te[1][3:0], 1'b0};
    state_next.s_te[0] = {state_reg.s_te[0][3:0], BTN_TEST_RESET};
    state_next.s_en[0] = {state_reg.s_en[0][3:0], BTN_ENTER};
    state_next.s_up[0] = {state_reg.s_up[0][3:0], BTN_UP};
    state_next.s_dn[0] = {state_reg.s_dn[0][3:0], BTN_DOWN};
    state_next.s_run = {state_reg.s_run[0], MOTOR_RUNNING};
    state_next.s_cur = {state_reg.s_cur[0], CURRENT_FLOWING};
    state_next.s_trip = {state_reg.s_trip[0], PROT_TRIP};
    state_next.s_thb = {state_reg.s_thb[0], THERMAL_BUILDUP_CURVE};
    state_next.s_com = {state_reg.s_com[0], COMM_ACTIVE};
    state_next.s_lnk = {state_reg.s_lnk[0], LINK_LOST};
    state_next.s_mem = {state_reg.s_mem[0], BACKUP_FAULT};
    raw_sync = '0;
    state_next.p_te = {state_reg.p_te[2:0], state_reg.s_te[0][1]};
    state_next.p_en = {state_reg.p_en[2:0], state_reg.s_en[0][1]};
    state_next.p_up = {state_reg.p_up[2:0], state_reg.s_up[0][1]};
    state_next.p_dn = {state_reg.p_dn[2:0], state_reg.s_dn[0][1]};
    te = state_reg.p_te[0] & ~state_reg.p_te[1];
    en = state_reg.p_en[0] & ~state_reg.p_en[1];
    up = state_reg.p_up[0] & ~state_reg.p_up[1];
    dn = state_reg.p_dn[0] & ~state_reg.p_dn[1];
    both_ud = (up & state_reg.p_dn[0]) | (dn & state_reg.p_up[0]);
    both_et = (te & state_reg.p_en[0]) | (en & state_reg.p_te[0]);
    state_next.inc = 1'b0;
    state_next.dec = 1'b0;
    state_next.store = 1'b0;
    state_next.heat_clr = 1'b0;
    state_next.commit = 1'b0;
    // protection trip arrives: log cause, oldest dropped when full
    if (state_reg.s_trip[1] && !state_reg.tripped) begin
      state_next.tripped = 1'b1;
      state_next.overload = (PROT_CAUSE == CAUSE_OVERLOAD);
      state_next.hist = {state_reg.hist[HIST_DEPTH-2:0], PROT_CAUSE};
      if (state_reg.hcnt < 3'(HIST_DEPTH)) state_next.hcnt = state_reg.hcnt + 3'h1;
    end
    if (both_et && state_reg.tripped && !state_reg.s_run[1]) begin
      state_next.tripped = 1'b0;
      state_next.heat_clr = state_reg.overload;
      state_next.scr = SCR_MEAS;
    end else if (both_ud) begin
      state_next.scr = SCR_HIST;
      state_next.hidx = 3'h0;
    end else begin
      unique case (state_reg.scr)
        SCR_MEAS, SCR_TEST: begin
          if (te && !state_reg.s_run[1]) begin
            if (!state_reg.tripped) begin
              state_next.tripped = 1'b1;
              state_next.overload = 1'b0;
              state_next.scr = SCR_TEST;
            end else begin
              state_next.tripped = 1'b0;
              state_next.scr = SCR_MEAS;
              // plain reset keeps heat in build-up mode
              state_next.heat_clr = state_reg.overload & ~state_reg.s_thb[1];
            end
          end else if (en && state_reg.scr == SCR_MEAS) begin
            state_next.scr = SCR_GROUP;
          end else if ((up || dn) && state_reg.frozen) begin
            state_next.frozen = 1'b0;
          end
        end
        SCR_GROUP: begin
          if (te) state_next.scr = SCR_MEAS;
          else if (en) begin
            state_next.scr = SCR_ITEM;
            state_next.item = 5'h0;
          end else if (up) state_next.grp = (state_reg.grp == 5'(GROUPS - 1)) ? 5'h0 : state_reg.grp + 5'h1;
          else if (dn) state_next.grp = (state_reg.grp == 5'h0) ? 5'(GROUPS - 1) : state_reg.grp - 5'h1;
        end
        SCR_ITEM: begin
          if (te) state_next.scr = SCR_GROUP;
          else if (en) state_next.scr = SCR_VALUE;
          else if (up) state_next.item = (state_reg.item == 5'(ITEMS - 1)) ? 5'h0 : state_reg.item + 5'h1;
          else if (dn) state_next.item = (state_reg.item == 5'h0) ? 5'(ITEMS - 1) : state_reg.item - 5'h1;
        end
        SCR_VALUE: begin
          if (up || dn) begin
            state_next.scr = state_reg.unlocked ? SCR_EDIT : SCR_PASS;
            state_next.pass = 8'hFF;
          end else if (en) state_next.item = (state_reg.item == 5'(ITEMS - 1)) ? 5'h0 : state_reg.item + 5'h1;
          else if (te) state_next.item = (state_reg.item == 5'h0) ? 5'(ITEMS - 1) : state_reg.item - 5'h1;
        end
        SCR_PASS: begin
          if (up) state_next.pass = state_reg.pass + 8'h01;
          else if (dn) state_next.pass = state_reg.pass - 8'h01;
          else if (en) begin
            state_next.scr = (state_reg.pass == PASSWORD) ? SCR_EDIT : SCR_VALUE;
            state_next.unlocked = (state_reg.pass == PASSWORD);
            state_next.unlock_cnt = '0;
          end else if (te) state_next.scr = SCR_VALUE;
        end
        SCR_EDIT: begin
          state_next.inc = up;
          state_next.dec = dn;
          if (up || dn) state_next.unlock_cnt = '0;
          if (en) begin
            state_next.store = 1'b1;
            state_next.scr = SCR_VALUE;
            state_next.unlock_cnt = '0;
          end
        end
        SCR_HIST: begin
          if (te) state_next.scr = SCR_MEAS;
          else if (en && state_reg.hcnt != 3'h0) state_next.scr = SCR_DETAIL;
          else if (up && state_reg.hidx + 3'h1 < state_reg.hcnt) state_next.hidx = state_reg.hidx + 3'h1;
          else if (dn && state_reg.hidx != 3'h0) state_next.hidx = state_reg.hidx - 3'h1;
        end
        SCR_DETAIL: begin
          if (te || en) state_next.scr = SCR_HIST;
        end
      endcase
    end
    if (state_reg.unlocked && state_reg.scr != SCR_EDIT) begin
      if (state_reg.unlock_cnt >= 36'(UNLOCK_CYCLES - 1)) state_next.unlocked = 1'b0;
      else state_next.unlock_cnt = state_reg.unlock_cnt + 36'h1;
    end
    // rotation and freeze
    if (state_reg.scr == SCR_MEAS && state_reg.p_en[0] && !state_reg.frozen) begin
      if (state_reg.hold_cnt >= HOLD_CYCLES - 1) state_next.frozen = 1'b1;
      else state_next.hold_cnt = state_reg.hold_cnt + 32'h1;
    end else state_next.hold_cnt = '0;
    if (!state_reg.frozen) begin
      if (state_reg.rot_cnt >= ROT_CYC - 1) begin
        state_next.rot_cnt = '0;
        state_next.phase = (state_reg.phase == 2'h2) ? 2'h0 : state_reg.phase + 2'h1;
      end else state_next.rot_cnt = state_reg.rot_cnt + 32'h1;
    end
    if (state_reg.blink_cnt >= BLINK_CYCLES - 1) begin
      state_next.blink_cnt = '0;
      state_next.blink = ~state_reg.blink;
    end else state_next.blink_cnt = state_reg.blink_cnt + 32'h1;
    // bar clamps into its 50..120 span
    state_next.bar = (LOAD_FACTOR < LOAD_BAR_LO) ? LOAD_BAR_LO :
                     (LOAD_FACTOR > LOAD_BAR_HI) ? LOAD_BAR_HI : LOAD_FACTOR;
    state_next.bar_hi = (LOAD_FACTOR >= LOAD_BAR_HI) & state_reg.blink;
    state_next.comm_lamp = state_reg.s_com[1] & state_reg.blink;
    if (state_reg.s_lnk[1]) state_next.link_f = 1'b1;
    if (state_reg.s_mem[1]) state_next.mem_f = 1'b1;
    // run time: uncommitted part is simply lost on power loss
    if (!state_reg.loaded) begin
      state_next.loaded = 1'b1;
      state_next.tot_h = NV_RUN_HOURS;
    end
    if (state_reg.s_cur[1]) begin
      if (state_reg.hour_cnt >= 38'(HOUR_CYCLES - 1)) begin
        state_next.hour_cnt = '0;
        state_next.op_h = state_reg.op_h + 14'h1;
        state_next.tot_h = state_reg.tot_h + 14'h1;
      end else state_next.hour_cnt = state_reg.hour_cnt + 38'h1;
      if (state_reg.commit_cnt >= 36'(COMMIT_CYCLES - 1)) begin
        state_next.commit_cnt = '0;
        state_next.commit = 1'b1;
      end else state_next.commit_cnt = state_reg.commit_cnt + 36'h1;
    end else begin
      state_next.op_h = '0;
      state_next.hour_cnt = '0;
    end
    lim = (RUNTIME_LIMIT_HOURS < RUNLIM_MIN) ? RUNLIM_MIN :
          (RUNTIME_LIMIT_HOURS > RUNLIM_MAX) ? RUNLIM_MAX : RUNTIME_LIMIT_HOURS;
    state_next.rt_alarm = (state_reg.tot_h >= lim);
    state_next.alarm_ct = (state_reg.tot_h >= lim) & ALARM_SRC_RUNTIME;
    if (edge_of(raw_sync)) state_next.pass = state_next.pass;
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_reg <= '0;
    end else if (CLK_EN) begin
      state_reg <= state_next;
    end
  end

  assign SCREEN = state_reg.scr;
  assign TRIPPED = state_reg.tripped;
  assign TEST_SHOWN = (state_reg.scr == SCR_TEST);
  assign THERMAL_CLEAR = state_reg.heat_clr;
  assign GROUP_SEL = state_reg.grp;
  assign ITEM_SEL = state_reg.item;
  assign PASS_VALUE = state_reg.pass;
  assign VALUE_FLICKER = (state_reg.scr == SCR_EDIT) & state_reg.blink;
  assign VALUE_INC = state_reg.inc;
  assign VALUE_DEC = state_reg.dec;
  assign VALUE_STORE = state_reg.store;
  assign UNLOCKED = state_reg.unlocked;
  assign HIST_CAUSE = (state_reg.hcnt == 3'h0) ? CAUSE_NONE : state_reg.hist[state_reg.hidx];
  assign HIST_INDEX = state_reg.hidx;
  assign HIST_COUNT = state_reg.hcnt;
  assign PHASE_SEL = state_reg.phase;
  assign PHASE_FLICKER = state_reg.frozen & state_reg.blink;
  assign LOAD_BAR = state_reg.bar;
  assign LOAD_BAR_FLICKER = state_reg.bar_hi;
  assign COMM_LAMP = state_reg.comm_lamp;
  assign LINK_FAULT = state_reg.link_f;
  assign MEM_FAULT = state_reg.mem_f;
  assign RUNTIME_LIMIT_ALARM = state_reg.rt_alarm;
  assign ALARM_CONTACT = state_reg.alarm_ct;
  assign OP_HOURS = state_reg.op_h;
  assign TOTAL_HOURS = state_reg.tot_h;
  assign NV_COMMIT = state_reg.commit;
endmodule : relay_panel_operation_logic

// File: sim/relay_panel_props.sv
`timescale 1ns/100ps
module relay_panel_props
  import panel_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic BTN_ENTER,
  input wire logic MOTOR_RUNNING,
  input wire logic CURRENT_FLOWING,
  input wire logic PROT_TRIP,
  input wire logic [3:0] SCREEN,
  input wire logic TRIPPED,
  input wire logic TEST_SHOWN,
  input wire logic [2:0] HIST_COUNT,
  input wire logic [1:0] PHASE_SEL,
  input wire logic [7:0] LOAD_BAR,
  input wire logic LINK_FAULT,
  input wire logic MEM_FAULT,
  input wire logic [13:0] OP_HOURS
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  sequence s_meas_idle;
    SCREEN == SCR_MEAS && !BTN_ENTER;
  endsequence
  sequence s_enter_held;
    BTN_ENTER [*4];
  endsequence
  a_enter_opens_group: assert property (s_meas_idle ##1 s_enter_held |-> ##[1:2] SCREEN == SCR_GROUP)
    else $error("enter did not open group select");
  a_link_latch: assert property (LINK_FAULT |=> LINK_FAULT)
    else $error("link fault dropped");
  a_mem_latch: assert property ($rose(MEM_FAULT) |-> MEM_FAULT [*8])
    else $error("memory fault dropped");
  a_hist_bound: assert property (HIST_COUNT <= 3'h5)
    else $error("history count above five");
  a_bar_span: assert property (LOAD_BAR != 8'h00 |-> LOAD_BAR >= LOAD_BAR_LO && LOAD_BAR <= LOAD_BAR_HI)
    else $error("load bar out of span");
  a_phase_step: assert property ($changed(PHASE_SEL) |->
    PHASE_SEL == (($past(PHASE_SEL) == 2'h2) ? 2'h0 : $past(PHASE_SEL) + 2'h1))
    else $error("phase did not step in order");
  a_idle_hours: assert property (!CURRENT_FLOWING [*5] |-> OP_HOURS == 14'h0000)
    else $error("operating time nonzero without current");
  a_test_locked: assert property ((MOTOR_RUNNING && !PROT_TRIP) [*6] |-> !$rose(TEST_SHOWN))
    else $error("test accepted while running");
  a_test_trips: assert property ($rose(TEST_SHOWN) |-> TRIPPED)
    else $error("test shown without trip");
endmodule : relay_panel_props

// File: sim/panel_operator.sv
`timescale 1ns/100ps
module panel_operator (
  input wire logic clk,
  output logic btn_test,
  output logic btn_enter,
  output logic btn_up,
  output logic btn_down
);
  logic [3:0] held;
  assign {btn_down, btn_up, btn_enter, btn_test} = held;
  initial held = 4'h0;
  // a second button joins while the first is held; gap lets the answer land
  task automatic press(input logic [3:0] first, input logic [3:0] second, input int hold);
    @(negedge clk);
    held = first;
    @(negedge clk);
    held = first | second;
    repeat (hold) @(negedge clk);
    held = 4'h0;
    repeat (6) @(negedge clk);
  endtask : press
endmodule : panel_operator

// File: sim/relay_panel_operation_logic_tb_top.sv
`timescale 1ns/100ps
module relay_panel_operation_logic_tb_top;
  import panel_pkg::*;
  logic CORE_CLK, RST_N, MOTOR_RUNNING, CURRENT_FLOWING, PROT_TRIP, THERMAL_BUILDUP_CURVE, COMM_ACTIVE;
  logic LINK_LOST, BACKUP_FAULT, ALARM_SRC_RUNTIME, BTN_TEST_RESET, BTN_ENTER, BTN_UP, BTN_DOWN;
  logic [3:0] PROT_CAUSE, SCREEN, HIST_CAUSE;
  logic [7:0] LOAD_FACTOR, LOAD_BAR, PASS_VALUE;
  logic [13:0] RUNTIME_LIMIT_HOURS, NV_RUN_HOURS, OP_HOURS;
  logic TRIPPED, TEST_SHOWN, THERMAL_CLEAR, VALUE_FLICKER, UNLOCKED, LOAD_BAR_FLICKER, COMM_LAMP;
  logic LINK_FAULT, MEM_FAULT, RUNTIME_LIMIT_ALARM, ALARM_CONTACT, NV_COMMIT, CLK_EN, VALUE_STORE;
  logic [13:0] TOTAL_HOURS;
  logic [4:0] GROUP_SEL, ITEM_SEL;
  logic [2:0] HIST_COUNT;
  logic [1:0] PHASE_SEL;
  localparam logic [3:0] B_T = 4'h1, B_E = 4'h2, B_U = 4'h4, B_D = 4'h8;
  int n_errors, check_count, n_clr, n_com, n_bar, n_lamp, n_st, t;
  relay_panel_operation_logic #(.ROT_CYC(20), .HOLD_CYCLES(10), .UNLOCK_CYCLES(50), .COMMIT_CYCLES(30),
    .HOUR_CYCLES(40), .BLINK_CYCLES(4)) dut (.CORE_CLK, .RST_N, .CLK_EN, .BTN_TEST_RESET, .BTN_ENTER,
    .BTN_UP, .BTN_DOWN, .MOTOR_RUNNING, .CURRENT_FLOWING, .PROT_TRIP, .PROT_CAUSE, .THERMAL_BUILDUP_CURVE,
    .LOAD_FACTOR, .COMM_ACTIVE, .LINK_LOST, .BACKUP_FAULT, .RUNTIME_LIMIT_HOURS, .ALARM_SRC_RUNTIME,
    .NV_RUN_HOURS, .SCREEN, .TRIPPED, .TEST_SHOWN, .THERMAL_CLEAR, .GROUP_SEL, .ITEM_SEL, .PASS_VALUE,
    .VALUE_FLICKER, .VALUE_INC(), .VALUE_DEC(), .VALUE_STORE, .UNLOCKED, .HIST_CAUSE, .HIST_INDEX(),
    .HIST_COUNT, .PHASE_SEL, .PHASE_FLICKER(), .LOAD_BAR, .LOAD_BAR_FLICKER, .COMM_LAMP, .LINK_FAULT,
    .MEM_FAULT, .RUNTIME_LIMIT_ALARM, .ALARM_CONTACT, .OP_HOURS, .TOTAL_HOURS, .NV_COMMIT);
  panel_operator op (.clk(CORE_CLK), .btn_test(BTN_TEST_RESET), .btn_enter(BTN_ENTER), .btn_up(BTN_UP),
    .btn_down(BTN_DOWN));
  initial begin
    CORE_CLK = 1'b0;
    forever #20 CORE_CLK = ~CORE_CLK;
  end
  always @(posedge CORE_CLK) begin
    n_clr <= n_clr + int'(THERMAL_CLEAR === 1'b1);
    n_com <= n_com + int'(NV_COMMIT === 1'b1);
    n_st <= n_st + int'(VALUE_STORE === 1'b1);
    n_bar <= n_bar + int'($changed(LOAD_BAR_FLICKER));
    n_lamp <= n_lamp + int'($changed(COMM_LAMP));
  end
  task automatic w(input int n);
    repeat (n) @(negedge CORE_CLK);
  endtask : w
  task automatic rst();
    RST_N = 1'b0;
    w(20);
    RST_N = 1'b1;
    w(2);
  endtask : rst
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  task automatic trip(input logic [3:0] cause);
    PROT_CAUSE = cause;
    PROT_TRIP = 1'b1;
    w(4);
    PROT_TRIP = 1'b0;
    w(4);
  endtask : trip
  task automatic wrap_up();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up
  initial begin
    #(40 * 20000);
    n_errors++;
    wrap_up();
  end
  initial begin
    {MOTOR_RUNNING, CURRENT_FLOWING, PROT_TRIP, THERMAL_BUILDUP_CURVE, COMM_ACTIVE, LINK_LOST} = 6'h00;
    BACKUP_FAULT = 1'b0;
    CLK_EN = 1'b1;
    ALARM_SRC_RUNTIME = 1'b1;
    PROT_CAUSE = 4'h0;
    LOAD_FACTOR = 8'h14;
    RUNTIME_LIMIT_HOURS = 14'h0003;
    NV_RUN_HOURS = 14'h0000;
    rst();
    MOTOR_RUNNING = 1'b1;
    op.press(B_T, 4'h0, 4);
    chk("tripped", 1'b0, TRIPPED);
    MOTOR_RUNNING = 1'b0;
    w(4);
    op.press(B_T, 4'h0, 4);
    chk("test", 2'h3, {TRIPPED, TEST_SHOWN});
    op.press(B_T, 4'h0, 4);
    chk("tripped", 1'b0, TRIPPED);
    chk("screen", SCR_MEAS, SCREEN);
    op.press(B_D, B_U, 4);
    chk("cause", CAUSE_NONE, HIST_CAUSE);
    chk("screen", SCR_HIST, SCREEN);
    rst();
    // each logged trip must be cleared, a standing trip masks the next one
    for (int k = 1; k <= 6; k++) begin
      trip(4'(k));
      op.press(B_T, 4'h0, 4);
    end
    chk("count", 3'h5, HIST_COUNT);
    op.press(B_D, B_U, 4);
    chk("cause", 4'h6, HIST_CAUSE);
    for (int k = 1; k <= 4; k++) begin
      op.press(B_U, 4'h0, 4);
      chk("cause", 4'(6 - k), HIST_CAUSE);
    end
    op.press(B_E, 4'h0, 4);
    chk("screen", SCR_DETAIL, SCREEN);
    rst();
    op.press(B_E, 4'h0, 4);
    op.press(B_U, 4'h0, 4);
    chk("group", 5'h01, GROUP_SEL);
    op.press(B_E, 4'h0, 4);
    op.press(B_U, 4'h0, 4);
    chk("item", 5'h01, ITEM_SEL);
    op.press(B_E, 4'h0, 4);
    chk("screen", SCR_VALUE, SCREEN);
    op.press(B_U, 4'h0, 4);
    chk("screen", SCR_PASS, SCREEN);
    op.press(B_U, 4'h0, 4);
    chk("pass", PASSWORD, PASS_VALUE);
    op.press(B_E, 4'h0, 4);
    chk("screen", SCR_EDIT, SCREEN);
    op.press(B_E, 4'h0, 4);
    chk("flicker", 1'b0, VALUE_FLICKER);
    chk("stores", 16'd1, 16'(n_st));
    op.press(B_E, 4'h0, 4);
    chk("item", 5'h02, ITEM_SEL);
    op.press(B_T, 4'h0, 4);
    chk("item", 5'h01, ITEM_SEL);
    chk("unlocked", 1'b1, UNLOCKED);
    w(60);
    chk("unlocked", 1'b0, UNLOCKED);
    rst();
    {MOTOR_RUNNING, CURRENT_FLOWING} = 2'h3;
    w(60);
    t = n_com;
    w(300);
    chk("commits", 16'd10, 16'(n_com - t));
    chk("alarm", 1'b0, RUNTIME_LIMIT_ALARM);
    w(80);
    chk("alarm", 2'h3, {RUNTIME_LIMIT_ALARM, ALARM_CONTACT});
    chk("total hours", 14'd10, TOTAL_HOURS);
    {MOTOR_RUNNING, CURRENT_FLOWING} = 2'h0;
    w(8);
    chk("op hours", 14'h0000, OP_HOURS);
    chk("bar", LOAD_BAR_LO, LOAD_BAR);
    LOAD_FACTOR = 8'h96;
    COMM_ACTIVE = 1'b1;
    {LINK_LOST, BACKUP_FAULT} = 2'h3;
    w(8);
    {LINK_LOST, BACKUP_FAULT} = 2'h0;
    t = n_bar + n_lamp;
    w(20);
    chk("bar", LOAD_BAR_HI, LOAD_BAR);
    chk("blinks", 1'b1, n_bar + n_lamp > t + 6);
    chk("faults", 2'h3, {LINK_FAULT, MEM_FAULT});
    rst();
    THERMAL_BUILDUP_CURVE = 1'b1;
    trip(CAUSE_OVERLOAD);
    t = n_clr;
    op.press(B_T, 4'h0, 4);
    chk("heat clears", 16'd0, 16'(n_clr - t));
    trip(CAUSE_OVERLOAD);
    op.press(B_E, B_T, 4);
    chk("heat clears", 16'd1, 16'(n_clr - t));
    // enable low must freeze the whole panel, a press is then lost
    CLK_EN = 1'b0;
    op.press(B_T, 4'h0, 4);
    CLK_EN = 1'b1;
    w(4);
    chk("frozen", 1'b0, TRIPPED);
    wrap_up();
  end
endmodule : relay_panel_operation_logic_tb_top
bind relay_panel_operation_logic relay_panel_props u_props (.CORE_CLK, .RST_N, .BTN_ENTER, .MOTOR_RUNNING,
  .CURRENT_FLOWING, .PROT_TRIP, .SCREEN, .TRIPPED, .TEST_SHOWN, .HIST_COUNT, .PHASE_SEL, .LOAD_BAR,
  .LINK_FAULT, .MEM_FAULT, .OP_HOURS);
